// ==== ccr_control.sv ====
`timescale 1ns/10ps
module ccr_control
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // Register port
  input  wire logic [CCR_ADDR_W-1:0] reg_addr,
  input  wire logic [CCR_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [CCR_DATA_W-1:0] reg_rdata,
  // Analog front end
  input  wire logic                  cmp_analog_out,
  output logic                       cmp_enable,
  output logic                       cmp_speed_select,
  output logic                       cmp_reference_select,
  output logic      [CCR_NUM_CH-1:0] cmp_channel_onehot,
  output logic      [CCR_CH_W-1:0]   cmp_channel_select,
  // Output pin
  input  wire logic                  pin_direction_bit,
  output logic                       cmp_out_pin,
  output logic                       cmp_out_pin_oe
);

  ccr_ctrl_if cif ();

  ccr_ctrl_t                 ctrl_q;
  logic [CCR_DATA_W-1:0]     rdata_q;
  logic                      raw_meta_q;
  logic                      raw_sync_q;
  logic                      dir_meta_q;
  logic                      dir_sync_q;
  logic [CCR_DATA_W-1:0]     reg_view;

  // ******************************************************************
  // Input synchronisers
  // ******************************************************************
  // Comparator output is asynchronous to the clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      raw_meta_q <= 1'b0;
      raw_sync_q <= 1'b0;
    end else begin
      raw_meta_q <= cmp_analog_out;
      raw_sync_q <= raw_meta_q;
    end
  end

  // Direction defaults to input so the pin stays released
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dir_meta_q <= 1'b1;
      dir_sync_q <= 1'b1;
    end else begin
      dir_meta_q <= pin_direction_bit;
      dir_sync_q <= dir_meta_q;
    end
  end

  // ******************************************************************
  // Control register
  // ******************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q.enable   <= CCR_CTRL_RESET[CCR_BIT_ENABLE];
      ctrl_q.pin_oe   <= CCR_CTRL_RESET[CCR_BIT_OE];
      ctrl_q.polarity <= CCR_CTRL_RESET[CCR_BIT_POL];
      ctrl_q.speed    <= CCR_CTRL_RESET[CCR_BIT_SPEED];
      ctrl_q.ref_sel  <= CCR_CTRL_RESET[CCR_BIT_REF];
      ctrl_q.channel  <= CCR_CTRL_RESET[CCR_CH_HI:CCR_CH_LO];
    end else if (reg_write && reg_addr == CCR_ADDR_CTRL) begin
      // Status bit dropped from the stored image
      ctrl_q.enable   <= reg_wdata[CCR_BIT_ENABLE];
      ctrl_q.pin_oe   <= reg_wdata[CCR_BIT_OE];
      ctrl_q.polarity <= reg_wdata[CCR_BIT_POL];
      ctrl_q.speed    <= reg_wdata[CCR_BIT_SPEED];
      ctrl_q.ref_sel  <= reg_wdata[CCR_BIT_REF];
      ctrl_q.channel  <= reg_wdata[CCR_CH_HI:CCR_CH_LO];
    end
  end

  assign cif.ctrl       = ctrl_q;
  assign cif.raw_result = raw_sync_q;

  ccr_output_logic u_out (
    .cif            (cif.out),
    .clk_sys        (clk_sys),
    .reset          (reset),
    .pin_direction_bit (dir_sync_q),
    .cmp_out_pin    (cmp_out_pin),
    .cmp_out_pin_oe (cmp_out_pin_oe)
  );

  // ******************************************************************
  // Analog controls
  // ******************************************************************
  assign cmp_enable           = ctrl_q.enable;
  assign cmp_speed_select     = ctrl_q.speed;
  assign cmp_reference_select = ctrl_q.ref_sel;
  assign cmp_channel_select   = ctrl_q.channel;

  // One switch per input pin; none closed while disabled saves current
  genvar gi;
  generate
    for (gi = 0; gi < CCR_NUM_CH; gi++) begin : g_ch
      assign cmp_channel_onehot[gi] = ctrl_q.enable &&
        (ctrl_q.channel == CCR_CH_W'(gi));
    end
  endgenerate

  // ******************************************************************
  // Read path
  // ******************************************************************
  always_comb begin
    reg_view                  = CCR_READ_UNMAPPED;
    reg_view[CCR_BIT_ENABLE]  = ctrl_q.enable;
    reg_view[CCR_BIT_RESULT]  = cif.result;
    reg_view[CCR_BIT_OE]      = ctrl_q.pin_oe;
    reg_view[CCR_BIT_POL]     = ctrl_q.polarity;
    reg_view[CCR_BIT_SPEED]   = ctrl_q.speed;
    reg_view[CCR_BIT_REF]     = ctrl_q.ref_sel;
    reg_view[CCR_CH_HI:CCR_CH_LO] = ctrl_q.channel;
  end

  // Data held only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_q <= CCR_READ_UNMAPPED;
    end else if (reg_read && reg_addr == CCR_ADDR_CTRL) begin
      rdata_q <= reg_view;
    end else begin
      rdata_q <= CCR_READ_UNMAPPED;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// ==== ccr_control_monitor.sv ====
`timescale 1ns/10ps
module ccr_control_monitor (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Comparator side
  input wire logic       cmp_enable,
  input wire logic [3:0] cmp_channel_onehot,
  input wire logic [1:0] cmp_channel_select,
  input wire logic       cmp_out_pin,
  input wire logic       cmp_out_pin_oe
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic rd0;
  logic wr0;
  assign rd0 = reg_read && reg_addr == 4'h0;
  assign wr0 = reg_write && reg_addr == 4'h0;
  reset_off_a: assert property (
    $past(reset) |-> !cmp_enable && !cmp_out_pin_oe) else $error("not off");
  write_store_a: assert property (
    wr0 |=> cmp_enable == $past(reg_wdata[7])
      && cmp_channel_select == $past(reg_wdata[1:0])) else $error("store");
  read_view_a: assert property (
    rd0 |=> reg_rdata[7] == $past(cmp_enable)
      && reg_rdata[1:0] == $past(cmp_channel_select)) else $error("view");
  onehot_sel_a: assert property (
    cmp_channel_onehot == (cmp_enable ? 4'h1 << cmp_channel_select : 4'h0))
    else $error("onehot");
  pin_drive_a: assert property (
    cmp_out_pin_oe |-> cmp_enable || $past(cmp_enable)) else $error("oe");
  pin_result_a: assert property (
    rd0 |=> reg_rdata[6] == cmp_out_pin) else $error("pin");
  off_result_a: assert property (
    rd0 && !cmp_enable && !$past(reg_write) && !$past(reg_write, 2)
      && !$past(reg_write, 3) |=> reg_rdata[6] == reg_rdata[4])
    else $error("preset");
  oe_bit_a: assert property (
    rd0 && cmp_out_pin_oe && !$past(reg_write) |=> reg_rdata[5])
    else $error("oe bit");
  // Scenarios that must be reached
  cover property (rd0 ##1 reg_rdata[7]);
  cover property ($rose(cmp_out_pin_oe));
  cover property (cmp_channel_onehot == 4'h8);
endmodule
bind ccr_control ccr_control_monitor ccr_control_monitor_i (
  .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .cmp_enable, .cmp_channel_onehot, .cmp_channel_select,
  .cmp_out_pin, .cmp_out_pin_oe);

// ==== ccr_control_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %h got %h", n, e, a); end end
module ccr_control_tb;
  import ccr_pkg::*;
  logic       clk_sys = 0, reset = 1, reg_write = 0, reg_read = 0;
  logic       cmp_analog_out = 0, pin_direction_bit = 1;
  logic       en, sp, rs, pin, oe;
  logic [1:0] ch;
  logic [3:0] reg_addr = 4'h0, onehot;
  logic [7:0] reg_wdata = 8'h00, rdata;
  int         miscompares = 0, samples_checked = 0;
  always #50 clk_sys = ~clk_sys;
  ccr_control ccr_control_i (.clk_sys, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata(rdata), .cmp_analog_out,
    .cmp_enable(en), .cmp_speed_select(sp), .cmp_reference_select(rs),
    .cmp_channel_onehot(onehot), .cmp_channel_select(ch),
    .pin_direction_bit, .cmp_out_pin(pin), .cmp_out_pin_oe(oe));
  // ****
  // Bus tasks
  // ****
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys) reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys) reg_read <= 1'b0;
    @(negedge clk_sys) `CHK("rdata", e, rdata)
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset;
    @(posedge clk_sys) reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'h0, 8'h00);
    `CHK("enable", 1'b0, en)
    $display("reset test done");
  endtask
  task t_fields;
    @(posedge clk_sys) cmp_analog_out <= 1'b1;
    wr(4'h0, 8'hFF);
    repeat (4) @(posedge clk_sys);
    rd(4'h0, 8'hBF);
    `CHK("controls", 5'h1F, {en, sp, rs, ch})
    $display("field test done");
  endtask
  task t_chan;
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, 8'h80 | 8'(c));
      @(negedge clk_sys) `CHK("onehot", 4'h1 << c, onehot)
      `CHK("channel", 2'(c), ch)
      `CHK("ref", 1'b0, rs)
      `CHK("speed", 1'b0, sp)
    end
    $display("channel test done");
  endtask
  task t_pol;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) cmp_analog_out <= i[0];
      wr(4'h0, {3'b100, i[1], 4'h0});
      repeat (4) @(posedge clk_sys);
      rd(4'h0, {1'b1, i[0] ^ i[1], 1'b0, i[1], 4'h0});
    end
    wr(4'h0, 8'h10);
    repeat (4) @(posedge clk_sys);
    rd(4'h0, 8'h50);
    $display("polarity test done");
  endtask
  task t_pin;
    @(posedge clk_sys) pin_direction_bit <= 1'b0;
    cmp_analog_out <= 1'b1;
    wr(4'h0, 8'hA0);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) `CHK("pin", 2'b11, {oe, pin})
    rd(4'h0, 8'hE0);
    @(posedge clk_sys) pin_direction_bit <= 1'b1;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) `CHK("oe dir", 1'b0, oe)
    @(posedge clk_sys) pin_direction_bit <= 1'b0;
    wr(4'h0, 8'h20);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) `CHK("oe off", 1'b0, oe)
    wr(4'h0, 8'h80);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) `CHK("oe bit", 1'b0, oe)
    $display("pin test done");
  endtask
  task t_unmap;
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h00);
    rd(4'h0, 8'hC0);
    $display("unmapped test done");
  endtask
  // Verdict, shared with the watchdog
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run is under 150 cycles
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
  initial begin
    t_reset;
    t_fields;
    t_chan;
    t_pol;
    t_pin;
    t_unmap;
    t_reset;
    give_verdict;
  end
endmodule

// ==== ccr_ctrl_if.sv ====
`timescale 1ns/10ps
interface ccr_ctrl_if;
  import ccr_pkg::*;

  ccr_ctrl_t  ctrl;
  logic       raw_result;
  logic       result;

  modport src (output ctrl, input result);
  modport out (input ctrl, input raw_result, output result);
endinterface

// ==== ccr_output_logic.sv ====
`timescale 1ns/10ps
module ccr_output_logic
  import ccr_pkg::*;
(
  ccr_ctrl_if.out   cif,
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Pin direction and pad
  input  wire logic pin_direction_bit,
  output logic      cmp_out_pin,
  output logic      cmp_out_pin_oe
);

  logic result_q;
  logic pin_q;
  logic pin_oe_q;

  // ******************************************************************
  // Result latch
  // ******************************************************************
  // Off comparator reads the polarity bit, so latches can be preset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result_q <= 1'b0;
    end else if (cif.ctrl.enable) begin
      result_q <= cif.raw_result ^ cif.ctrl.polarity;
    end else begin
      result_q <= cif.ctrl.polarity;
    end
  end

  assign cif.result = result_q;

  // ******************************************************************
  // Pin driver
  // ******************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_q    <= result_q;
      pin_oe_q <= cif.ctrl.pin_oe & cif.ctrl.enable
                  & ~pin_direction_bit;
    end
  end

  assign cmp_out_pin    = pin_q;
  assign cmp_out_pin_oe = pin_oe_q;

endmodule

// ==== ccr_pkg.sv ====
package ccr_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam int             CCR_ADDR_W       = 4;
  localparam int             CCR_DATA_W       = 8;
  localparam logic [3:0]     CCR_ADDR_CTRL    = 4'h0;
  localparam logic [7:0]     CCR_CTRL_RESET   = 8'h00;
  localparam logic [7:0]     CCR_READ_UNMAPPED = 8'h00;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int             CCR_BIT_ENABLE   = 7;
  localparam int             CCR_BIT_RESULT   = 6;
  localparam int             CCR_BIT_OE       = 5;
  localparam int             CCR_BIT_POL      = 4;
  localparam int             CCR_BIT_SPEED    = 3;
  localparam int             CCR_BIT_REF      = 2;
  localparam int             CCR_CH_HI        = 1;
  localparam int             CCR_CH_LO        = 0;
  localparam int             CCR_CH_W         = 2;
  localparam int             CCR_NUM_CH       = 4;

  // Writable bits: everything except the status bit
  localparam logic [7:0]     CCR_WRITE_MASK   = 8'hBF;

  typedef struct packed {
    logic                    enable;
    logic                    pin_oe;
    logic                    polarity;
    logic                    speed;
    logic                    ref_sel;
    logic [CCR_CH_W-1:0]     channel;
  } ccr_ctrl_t;

endpackage
